// >>> src/lport_defs.svh
// Constants for the listener-only instrument bus port
`ifndef LPORT_DEFS_SVH
`define LPORT_DEFS_SVH

`define LP_ADDR_MAX 5'h1E
`define LP_FIFO_DEPTH 4
`define LP_DATA_W 8
`define LP_RS_DATA 3'h0
`define LP_RS_STATUS 3'h1
`define LP_RS_ADDR 3'h2
`define LP_RS_CTRL 3'h3
`define LP_ST_DATA_BIT 0
`define LP_ST_ADDR_BIT 1
`define LP_ST_ATN_BIT 2
`define LP_ST_REN_BIT 3
`define LP_ST_IFC_BIT 4
`define LP_ST_BADADR_BIT 5

`endif

// >>> src/lport_pkg.sv
// Types for the listener-only instrument bus port
package lport_pkg;
    typedef enum logic [2:0] {
        HS_READY = 3'h1,
        HS_ACCEPT = 3'h2,
        HS_RELEASE = 3'h4
    } hs_state_t;
    typedef logic [7:0] byte_t;
endpackage

// >>> src/lport_stream_if.sv
// Byte stream carrier between the handshake engine and the receive FIFO
`timescale 1ns/1ps
interface lport_stream_if;
    logic valid;
    logic ready;
    lport_pkg::byte_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> src/lport_fifo.sv
// Parameterised receive FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lport_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clocking
    input wire logic clk,
    input wire logic ce,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// >>> src/lport_handshake.sv
// Listener acceptor handshake: NRFD/NDAC sequencing per byte
`timescale 1ns/1ps
module lport_handshake (
    // Clocking
    input wire logic clk,
    input wire logic ce,
    input wire logic arst_n,
    // Synchronised bus lines, active high inside
    input wire logic dav,
    input wire logic [7:0] dio,
    input wire logic listen,
    // Line drives, active high inside
    output logic nrfd,
    output logic ndac,
    // Received byte stream
    lport_stream_if.src rx
);
    lport_pkg::hs_state_t state_r, state_nxt;
    lport_pkg::byte_t data_r;
    logic valid_r;

    // Ready only when rx.ready is high (FIFO room, or any command byte) and our last byte is gone
    wire can_take = listen && rx.ready && !valid_r;

    always_comb begin
        case (state_r)
            lport_pkg::HS_READY:
                state_nxt = (dav && can_take) ? lport_pkg::HS_ACCEPT
                                              : lport_pkg::HS_READY;
            lport_pkg::HS_ACCEPT:
                state_nxt = lport_pkg::HS_RELEASE;
            lport_pkg::HS_RELEASE:
                state_nxt = dav ? lport_pkg::HS_RELEASE : lport_pkg::HS_READY;
            default:
                state_nxt = lport_pkg::HS_READY;
        endcase
    end

    // NRFD drops when ready; NDAC drops only after byte latched
    assign nrfd = !(state_r == lport_pkg::HS_READY && can_take && !dav);
    assign ndac = (state_r == lport_pkg::HS_READY)
               || (state_r == lport_pkg::HS_ACCEPT);
    assign rx.valid = valid_r;
    assign rx.data = data_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= lport_pkg::HS_READY;
            data_r <= 8'h00;
            valid_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            if (state_r == lport_pkg::HS_READY && dav && can_take) begin
                data_r <= dio;
                valid_r <= 1'b1;
            end else if (rx.ready) begin
                valid_r <= 1'b0;
            end
        end
    end
endmodule

// >>> src/listener_only_instrument_bus_port.sv
// Top of the listener-only instrument bus port with processor side
`timescale 1ns/1ps
`include "lport_defs.svh"
module listener_only_instrument_bus_port (
    // Clock, reset and enable
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CE,
    // External bus data lines, negative-true
    input wire logic [7:0] DIO_N_I,
    output logic [7:0] DIO_N_O,
    output logic [7:0] DIO_N_OE_N,
    // External control lines
    input wire logic ATN_N,
    input wire logic IFC_N,
    input wire logic REN_N,
    input wire logic EOI_N,
    output logic SRQ_N_O,
    output logic SRQ_N_OE_N,
    // External handshake lines
    input wire logic DAV_N,
    output logic NRFD_N_O,
    output logic NRFD_N_OE_N,
    output logic NDAC_N_O,
    output logic NDAC_N_OE_N,
    // Address switch
    input wire logic [4:0] ADDR_SWITCH,
    // Microprocessor side
    input wire logic INTERFACE_SELECT_N,
    input wire logic [2:0] A,
    input wire logic RW,
    input wire logic [7:0] D_I,
    output logic [7:0] D_O,
    output logic D_OE_N,
    // Adapter indications
    output logic ADDRESS_SELECT_ENABLE_N,
    output logic BUS_INTERRUPT_REQUEST_N,
    output logic ADDRESS_VALID
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    wire [15:0] raw_pins = {ADDR_SWITCH, DIO_N_I, ATN_N, DAV_N, IFC_N};
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_r <= 16'hFFFF;
            sync2_r <= 16'hFFFF;
        end else if (CE) begin
            sync1_r <= raw_pins;
            sync2_r <= sync1_r;
        end
    end
    logic [1:0] ren1_r;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ren1_r <= 2'h3;
        end else if (CE) begin
            ren1_r <= {ren1_r[0], REN_N};
        end
    end

    // Negative-true lines become positive-true inside
    wire [4:0] sw_addr = sync2_r[15:11];
    wire [7:0] dio_pos = ~sync2_r[10:3];
    wire atn = !sync2_r[2];
    wire dav = !sync2_r[1];
    wire ifc = !sync2_r[0];
    wire ren = !ren1_r[1];
    // EOI is the unused fifth control line

    // ************************************************************
    // Addressing
    // ************************************************************
    wire addr_ok = (sw_addr <= `LP_ADDR_MAX);
    logic listen_r;
    logic ase_r;
    logic atn_d_r;
    // Under ATN a command byte arrives: listen address is 001xxxxx
    lport_stream_if hs_rx();
    lport_stream_if fifo_in();

    // ************************************************************
    // Handshake engine
    // ************************************************************
    logic nrfd;
    logic ndac;
    // ATN bytes are always taken so commands can change listen state
    wire hs_listen = atn || listen_r;
    lport_handshake u_hs (
        .clk(MCLK),
        .ce(CE),
        .arst_n(ARST_N),
        .dav(dav),
        .dio(dio_pos),
        .listen(hs_listen),
        .nrfd(nrfd),
        .ndac(ndac),
        .rx(hs_rx)
    );

    // Commands are consumed here; data goes on to the FIFO
    logic is_cmd_r;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            is_cmd_r <= 1'b0;
        end else if (CE) begin
            is_cmd_r <= atn;
        end
    end
    wire hs_is_cmd = is_cmd_r;
    assign fifo_in.valid = hs_rx.valid && !hs_is_cmd;
    assign fifo_in.data = hs_rx.data;
    assign hs_rx.ready = hs_is_cmd ? 1'b1 : fifo_in.ready;
    wire cmd_byte = hs_rx.valid && hs_is_cmd;
    wire [7:0] cmd = hs_rx.data;
    wire my_listen = cmd_byte && addr_ok
                  && (cmd == {3'h1, sw_addr});
    wire unlisten = cmd_byte && (cmd == 8'h3F);

    // ************************************************************
    // Receive FIFO
    // ************************************************************
    logic rx_valid;
    logic [7:0] rx_data;
    wire rd_data = !INTERFACE_SELECT_N && RW && (A == `LP_RS_DATA);
    logic rd_d_r;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_d_r <= 1'b0;
        end else if (CE) begin
            rd_d_r <= rd_data;
        end
    end
    // One pop per read strobe, at its trailing edge
    wire rd_pop = rd_d_r && !rd_data;
    lport_fifo #(.WIDTH(`LP_DATA_W), .DEPTH(`LP_FIFO_DEPTH)) u_fifo (
        .clk(MCLK),
        .ce(CE),
        .arst_n(ARST_N),
        .in_valid(fifo_in.valid),
        .in_data(fifo_in.data),
        .in_ready(fifo_in.ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rd_pop)
    );

    // ************************************************************
    // Listen state and indications
    // ************************************************************
    logic irq_en_r;
    logic irq_r;
    wire wr_ctrl = !INTERFACE_SELECT_N && !RW && (A == `LP_RS_CTRL);
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            listen_r <= 1'b0;
            ase_r <= 1'b0;
            atn_d_r <= 1'b0;
            irq_en_r <= 1'b1;
            irq_r <= 1'b0;
        end else if (CE) begin
            atn_d_r <= atn;
            if (ifc || unlisten) begin
                listen_r <= 1'b0;
            end else if (my_listen) begin
                listen_r <= 1'b1;
            end
            // Addressed event; set wins over a processor clear
            if (my_listen) begin
                ase_r <= 1'b1;
            end else if (wr_ctrl && D_I[1]) begin
                ase_r <= 1'b0;
            end
            if (wr_ctrl) begin
                irq_en_r <= D_I[0];
            end
            irq_r <= irq_en_r && (rx_valid || ase_r || ifc);
        end
    end
    assign ADDRESS_SELECT_ENABLE_N = !ase_r;
    assign BUS_INTERRUPT_REQUEST_N = !irq_r;
    assign ADDRESS_VALID = addr_ok;

    // ************************************************************
    // Processor read path
    // ************************************************************
    logic [7:0] status;
    always_comb begin
        status = 8'h00;
        status[`LP_ST_DATA_BIT] = rx_valid;
        status[`LP_ST_ADDR_BIT] = listen_r;
        status[`LP_ST_ATN_BIT] = atn;
        status[`LP_ST_REN_BIT] = ren;
        status[`LP_ST_IFC_BIT] = ifc;
        status[`LP_ST_BADADR_BIT] = !addr_ok;
    end
    // Address switch buffer drives the set address when selected
    wire [7:0] rd_mux = (A == `LP_RS_DATA) ? rx_data :
                        (A == `LP_RS_STATUS) ? status :
                        (A == `LP_RS_ADDR) ? {3'h0, sw_addr} :
                        8'h00;
    logic [7:0] d_o_r;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            d_o_r <= 8'h00;
        end else if (CE) begin
            d_o_r <= rd_mux;
        end
    end
    assign D_O = d_o_r;
    assign D_OE_N = !(!INTERFACE_SELECT_N && RW);

    // ************************************************************
    // Bus line drives
    // ************************************************************
    assign DIO_N_O = 8'hFF;
    assign DIO_N_OE_N = 8'hFF;
    assign SRQ_N_O = 1'b1;
    assign SRQ_N_OE_N = 1'b1;
    // Open collector: drive low only, release otherwise
    assign NRFD_N_O = 1'b0;
    assign NRFD_N_OE_N = !nrfd;
    assign NDAC_N_O = 1'b0;
    assign NDAC_N_OE_N = !ndac;
    wire unused_ok = atn_d_r ^ EOI_N ^ (|D_I[7:2]);
endmodule

// >>> testbench/lport_asserts.sv
// Checker for the listener-only instrument bus port
`timescale 1ns/1ps
module lport_asserts (
    // Clock and reset
    input wire logic MCLK,
    input wire logic ARST_N,
    // Bus side
    input wire logic [7:0] DIO_N_O,
    input wire logic [7:0] DIO_N_OE_N,
    input wire logic SRQ_N_O,
    input wire logic SRQ_N_OE_N,
    input wire logic DAV_N,
    input wire logic NRFD_N_O,
    input wire logic NRFD_N_OE_N,
    input wire logic NDAC_N_O,
    input wire logic NDAC_N_OE_N,
    input wire logic [4:0] ADDR_SWITCH,
    // Processor side
    input wire logic INTERFACE_SELECT_N,
    input wire logic RW,
    input wire logic D_OE_N,
    input wire logic ADDRESS_SELECT_ENABLE_N,
    input wire logic ADDRESS_VALID
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    property p_dio_off;
        DIO_N_OE_N == 8'hFF && DIO_N_O == 8'hFF;
    endproperty
    a_dio_off: assert property (p_dio_off)
        else $error("data line driven");
    property p_srq_off;
        SRQ_N_OE_N && SRQ_N_O;
    endproperty
    a_srq_off: assert property (p_srq_off)
        else $error("service request driven");
    property p_hs_level;
        !NRFD_N_O && !NDAC_N_O;
    endproperty
    a_hs_level: assert property (p_hs_level)
        else $error("handshake drive level wrong");
    property p_excl;
        NDAC_N_OE_N |-> !NRFD_N_OE_N;
    endproperty
    a_excl: assert property (p_excl)
        else $error("ready while accepted");
    property p_accept;
        $rose(NDAC_N_OE_N) |-> !$past(DAV_N) && !$past(DAV_N, 2);
    endproperty
    a_accept: assert property (p_accept)
        else $error("accept without data valid");
    property p_ndac_hold;
        NDAC_N_OE_N && !DAV_N |=> NDAC_N_OE_N;
    endproperty
    a_ndac_hold: assert property (p_ndac_hold)
        else $error("accept dropped while data valid");
    property p_rd_en;
        D_OE_N == !(!INTERFACE_SELECT_N && RW);
    endproperty
    a_rd_en: assert property (p_rd_en)
        else $error("read buffer enable wrong");
    property p_addr_valid;
        $stable(ADDR_SWITCH) [*4] |-> ADDRESS_VALID == (ADDR_SWITCH <= 5'h1E);
    endproperty
    a_addr_valid: assert property (p_addr_valid)
        else $error("address validity wrong");
    property p_ase;
        $fell(ADDRESS_SELECT_ENABLE_N) |-> ADDRESS_VALID;
    endproperty
    a_ase: assert property (p_ase)
        else $error("selected with bad address");
endmodule
bind listener_only_instrument_bus_port lport_asserts u_lport_asserts (
    .MCLK, .ARST_N, .DIO_N_O, .DIO_N_OE_N, .SRQ_N_O, .SRQ_N_OE_N, .DAV_N,
    .NRFD_N_O, .NRFD_N_OE_N, .NDAC_N_O, .NDAC_N_OE_N, .ADDR_SWITCH,
    .INTERFACE_SELECT_N, .RW, .D_OE_N, .ADDRESS_SELECT_ENABLE_N,
    .ADDRESS_VALID);

// >>> testbench/lport_talker.sv
// Behavioural controller acting as talker on the bus
`timescale 1ns/1ps
module lport_talker (
    // Clock
    input wire logic clk,
    // Handshake lines seen on the wire
    input wire logic nrfd_n,
    input wire logic ndac_n,
    // Lines driven by the controller
    output logic [7:0] dio_n,
    output logic dav_n,
    output logic atn_n
);
    // ****
    // Byte transfer
    // ****
    initial begin
        dio_n = 8'hFF;
        dav_n = 1'b1;
        atn_n = 1'b1;
    end
    // Released lines float to the pull-up level, never the last byte
    task automatic send(input lport_pkg::byte_t b, input logic atn,
                        input int slow, output logic ok);
        int n;
        n = 0;
        // Attention goes first so unaddressed devices turn ready
        @(posedge clk);
        atn_n <= !atn;
        do @(negedge clk); while (!nrfd_n && ++n < 40);
        ok = nrfd_n;
        if (ok) begin
            repeat (slow) @(posedge clk);
            @(posedge clk);
            dio_n <= ~b;
            @(posedge clk);
            dav_n <= 1'b0;
            n = 0;
            do @(negedge clk); while (!ndac_n && ++n < 60);
            ok = ndac_n;
            @(posedge clk);
            dav_n <= 1'b1;
            do @(negedge clk); while (ndac_n && ++n < 120);
            @(posedge clk);
            dio_n <= 8'hFF;
            atn_n <= 1'b1;
        end
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking testbench for the listener-only instrument bus port
`timescale 1ns/1ps
`include "lport_defs.svh"
module testbench;
    // ****
    // Stimulus and wiring
    // ****
    logic MCLK = 1'b0, ARST_N = 1'b0, IFC_N = 1'b1, sel_n = 1'b1, RW = 1'b1;
    logic [2:0] A = 3'h0;
    logic [7:0] D_I = 8'h00, dio_n, DIO_N_O, DIO_N_OE_N, D_O;
    logic [4:0] sw = 5'h1E;
    logic dav_n, atn_n, SRQ_N_O, SRQ_N_OE_N, NRFD_N_O, NRFD_N_OE_N;
    logic NDAC_N_O, NDAC_N_OE_N, D_OE_N, ase_n, irq_n, addr_ok;
    wire nrfd_line = NRFD_N_OE_N ? 1'b1 : NRFD_N_O;
    wire ndac_line = NDAC_N_OE_N ? 1'b1 : NDAC_N_O;
    int n_errors = 0, n_tests = 0, cyc = 0;
    always #5 MCLK = ~MCLK;
    lport_talker u_lport_talker (.clk(MCLK), .nrfd_n(nrfd_line),
        .ndac_n(ndac_line), .dio_n(dio_n), .dav_n(dav_n), .atn_n(atn_n));
    listener_only_instrument_bus_port u_listener_only_instrument_bus_port (
        .MCLK(MCLK), .ARST_N(ARST_N), .CE(1'b1), .DIO_N_I(dio_n),
        .DIO_N_O(DIO_N_O), .DIO_N_OE_N(DIO_N_OE_N), .ATN_N(atn_n),
        .IFC_N(IFC_N), .REN_N(1'b1), .EOI_N(1'b1), .SRQ_N_O(SRQ_N_O),
        .SRQ_N_OE_N(SRQ_N_OE_N), .DAV_N(dav_n), .NRFD_N_O(NRFD_N_O),
        .NRFD_N_OE_N(NRFD_N_OE_N), .NDAC_N_O(NDAC_N_O),
        .NDAC_N_OE_N(NDAC_N_OE_N), .ADDR_SWITCH(sw),
        .INTERFACE_SELECT_N(sel_n), .A(A), .RW(RW), .D_I(D_I), .D_O(D_O),
        .D_OE_N(D_OE_N), .ADDRESS_SELECT_ENABLE_N(ase_n),
        .BUS_INTERRUPT_REQUEST_N(irq_n), .ADDRESS_VALID(addr_ok));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge MCLK);
        sel_n <= 1'b0;
        A <= a;
        RW <= 1'b1;
        @(posedge MCLK);
        @(posedge MCLK);
        @(negedge MCLK) d = D_O;
        @(posedge MCLK) sel_n <= 1'b1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge MCLK);
        sel_n <= 1'b0;
        A <= a;
        RW <= 1'b0;
        D_I <= d;
        @(posedge MCLK);
        @(posedge MCLK);
        sel_n <= 1'b1;
        RW <= 1'b1;
    endtask
    task automatic settle();
        repeat (6) @(posedge MCLK);
        @(negedge MCLK);
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_static();
        chk("dio_oe_n", 8'hFF, DIO_N_OE_N);
        chk("srq", 8'h03, {SRQ_N_O, SRQ_N_OE_N});
        chk("ase_irq", 8'h03, {ase_n, irq_n});
        $display("test static done");
    endtask
    task automatic t_addr();
        logic [7:0] d;
        @(posedge MCLK) sw <= 5'h1F;
        settle();
        chk("valid_31", 8'h00, addr_ok);
        rd(`LP_RS_STATUS, d);
        chk("badaddr_bit", 8'h01, d[`LP_ST_BADADR_BIT]);
        @(posedge MCLK) sw <= 5'h1E;
        settle();
        chk("valid_30", 8'h01, addr_ok);
        rd(`LP_RS_ADDR, d);
        chk("addr_reg", 8'h1E, d[4:0]);
        $display("test address done");
    endtask
    task automatic t_listen();
        logic [7:0] d;
        logic ok;
        wr(`LP_RS_CTRL, 8'h01);
        u_lport_talker.send(8'h3E, 1'b1, 0, ok);
        chk("listen_ok", 8'h01, ok);
        settle();
        chk("ase_n", 8'h00, ase_n);
        chk("irq_n", 8'h00, irq_n);
        rd(`LP_RS_STATUS, d);
        chk("listen_bit", 8'h01, d[`LP_ST_ADDR_BIT]);
        $display("test listen done");
    endtask
    task automatic t_fill();
        logic [7:0] d;
        logic ok;
        int n;
        n = 0;
        for (int i = 0; i < 6; i++) begin
            u_lport_talker.send(8'hA0 + i, 1'b0, i, ok);
            if (!ok)
                break;
            n++;
        end
        chk("accepted", 8'(`LP_FIFO_DEPTH), 8'(n));
        for (int i = 0; i < n; i++) begin
            rd(`LP_RS_DATA, d);
            chk("byte", 8'hA0 + i, d);
        end
        rd(`LP_RS_STATUS, d);
        chk("data_bit", 8'h00, d[`LP_ST_DATA_BIT]);
        u_lport_talker.send(8'h5A, 1'b0, 0, ok);
        chk("after_drain", 8'h01, ok);
        rd(`LP_RS_DATA, d);
        chk("byte_5a", 8'h5A, d);
        $display("test fill done");
    endtask
    task automatic t_leave();
        logic [7:0] d;
        logic ok;
        u_lport_talker.send(8'h3F, 1'b1, 3, ok);
        chk("unlisten_ok", 8'h01, ok);
        rd(`LP_RS_STATUS, d);
        chk("unlisten", 8'h00, d[`LP_ST_ADDR_BIT]);
        u_lport_talker.send(8'h11, 1'b0, 0, ok);
        chk("not_listening", 8'h00, ok);
        wr(`LP_RS_CTRL, 8'h03);
        settle();
        chk("ase_cleared", 8'h01, ase_n);
        u_lport_talker.send(8'h3E, 1'b1, 0, ok);
        chk("relisten_ok", 8'h01, ok);
        @(posedge MCLK) IFC_N <= 1'b0;
        settle();
        rd(`LP_RS_STATUS, d);
        chk("ifc_bit", 8'h01, d[`LP_ST_IFC_BIT]);
        chk("ifc_unlisten", 8'h00, d[`LP_ST_ADDR_BIT]);
        @(posedge MCLK) IFC_N <= 1'b1;
        $display("test leave done");
    endtask
    // ****
    // Run control
    // ****
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge MCLK);
        ARST_N <= 1'b1;
        settle();
        t_static();
        t_addr();
        t_listen();
        t_fill();
        t_leave();
        summarize();
    end
endmodule
